// ==== pkg/shear_status_pkg.sv ====
// types shared by the status output logic
`default_nettype none
package shear_status_pkg;
	// gap sequence states, one-hot
	typedef enum logic [1:0] {
		GAP_IDLE = 2'b01,
		GAP_WAIT_CUT = 2'b10
	} gap_state_t;
	typedef logic [31:0] word_t;
endpackage
`default_nettype wire

// ==== pkg/shear_status_regs.svh ====
// register offsets, field positions, reset values and flag indices
`ifndef SHEAR_STATUS_REGS_SVH
`define SHEAR_STATUS_REGS_SVH
// apb byte offsets
`define OFS_STATUS 12'h000
`define OFS_ROUTE_LO 12'h004
`define OFS_ROUTE_HI 12'h008
`define OFS_HOME_LO 12'h00C
`define OFS_HOME_HI 12'h010
`define OFS_ALARM_POS 12'h014
`define OFS_REV_LIMIT 12'h018
`define OFS_ZERO_FREQ 12'h01C
`define OFS_PULSE_DIV 12'h020
`define OFS_MISS_LIMIT 12'h024
`define OFS_CTRL 12'h028
`define OFS_MAX_CORR 12'h02C
// control register fields
`define CTRL_WIN_EN 0
`define CTRL_GAP_EN 1
// reset values
`define RST_ROUTE 32'h0000_0000
`define RST_WORD 32'h0000_0000
`define RST_PULSE_DIV 32'h0000_0001
`define RST_MISS_LIMIT 32'h0000_0003
`define RST_CTRL 32'h0000_0001
// status flag indices
`define F_READY 0
`define F_CUT_PERMIT 1
`define F_PARKED 2
`define F_ALARM 3
`define F_LEN_PULSE 4
`define F_GAP_DONE 5
`define F_LINE_REV 6
`define F_FAULT 7
`define F_LINE_MOV 8
`define F_SIM_MOV 9
`define F_MISS_MARK 10
`define F_MARK_WIN 11
`define F_SYNTH_MARK 12
`define F_CORR_LIM 13
`define F_TEACH_DONE 14
`define F_UNUSED 15
// route field width and count of flag slots
`define ROUTE_W 4
`define N_FLAGS 16
`define N_LINES 8
`endif

// ==== verification/line_control_model.sv ====
// far-side line control model: cut-done answer, clear pin, pulse counter
`default_nettype none
module line_control_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic watch_line,
	input wire logic len_line,
	input wire logic clear_req,
	input wire logic [7:0] delay,
	output logic cut_done_pin,
	output logic fault_clear_pin,
	output logic [15:0] n_rise,
	output logic [15:0] n_high
);
	timeunit 1ns;
	timeprecision 1ns;
	logic watch_q; // last level of the watched line
	logic len_q; // last level of the length line
	logic armed_q; // a cut answer is pending
	logic [7:0] wait_q; // cycles waited so far
	logic [2:0] cut_q; // high-time left on the cut-done pin
	logic [2:0] clr_q; // high-time left on the clear pin
	// pins idle low; six cycles high so the synchroniser sees them
	assign cut_done_pin = (cut_q != 3'h0);
	assign fault_clear_pin = (clr_q != 3'h0);
	// answer, after a delay, each new rise of the line seen while idle (not armed, pin low)
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			watch_q <= 1'b0;
			armed_q <= 1'b0;
			wait_q <= 8'h00;
			cut_q <= 3'h0;
		end else begin
			watch_q <= watch_line;
			if (cut_q != 3'h0) begin
				cut_q <= cut_q - 3'h1;
			end else if (armed_q) begin
				wait_q <= wait_q + 8'h01;
				if (wait_q == delay) begin
					cut_q <= 3'h6;
					armed_q <= 1'b0;
				end
			end else if (watch_line && !watch_q) begin
				armed_q <= 1'b1;
				wait_q <= 8'h00;
			end
		end
	end
	// operator clear request becomes a clear pin pulse
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clr_q <= 3'h0;
		end else if (clear_req) begin
			clr_q <= 3'h6;
		end else if (clr_q != 3'h0) begin
			clr_q <= clr_q - 3'h1;
		end
	end
	// remote counter: rises and high cycles of the length line
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			len_q <= 1'b0;
			n_rise <= 16'h0000;
			n_high <= 16'h0000;
		end else begin
			len_q <= len_line;
			if (len_line && !len_q) begin
				n_rise <= n_rise + 16'h0001;
			end
			if (len_line) begin
				n_high <= n_high + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the status output logic
`include "shear_status_regs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import shear_status_pkg::*;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	word_t pwdata, prdata, rd;
	logic init_done, selftest_pass, at_sync_pos, carriage_fwd;
	logic line_step, line_fwd, gap_finished, error_event;
	logic mark_window_open, mark_seen, sheet_end, virt_mark_pending;
	logic teach_active, teach_captured, cut_done_pin, fault_clear_pin;
	logic return_go, error_report, clear_req, er;
	logic [31:0] carriage_pos;
	logic [15:0] enc_freq, virt_freq, corr_value, n_rise, n_high;
	logic [7:0] output_connector, delay;
	int n_fail, compares, n_ret, r0, h0;
	shear_status_output_logic dut_u (.clk, .resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .init_done,
		.selftest_pass, .at_sync_pos, .carriage_pos, .carriage_fwd,
		.line_step, .line_fwd, .enc_freq, .virt_freq, .gap_finished,
		.error_event, .mark_window_open, .mark_seen, .sheet_end,
		.virt_mark_pending, .corr_value, .teach_active, .teach_captured,
		.cut_done_pin, .fault_clear_pin, .output_connector, .return_go,
		.error_report);
	line_control_model model_u (.clk, .resetn,
		.watch_line(output_connector[1]), .len_line(output_connector[2]),
		.clear_req, .delay, .cut_done_pin, .fault_clear_pin, .n_rise,
		.n_high);
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// count return pulses seen at the clock edge
	always @(posedge clk) begin
		if (return_go === 1'b1) n_ret++;
	end
	task automatic fail(input string m);
		n_fail++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	// one compare for every result, words and single bits alike
	task automatic chk(input word_t g, input word_t e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// apb transfer: setup, access held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input word_t d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) fail("no apb answer");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input word_t d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input word_t e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	// status bit after inputs have settled
	task automatic st(input int b, input logic e);
		tick(2);
		xfer(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk({31'h0, rd[b]}, {31'h0, e});
	endtask
	// hardware line lags the flag by one more clock
	task automatic ln(input int i, input logic e);
		tick(3);
		chk({31'h0, output_connector[i]}, {31'h0, e});
	endtask
	// evenly spaced line counts, four clocks apart
	task automatic steps(input int n, input logic f);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			line_fwd <= f;
			line_step <= 1'b1;
			@(posedge clk);
			line_step <= 1'b0;
			tick(2);
		end
	endtask
	task automatic sheet();
		@(posedge clk);
		sheet_end <= 1'b1;
		@(posedge clk);
		sheet_end <= 1'b0;
	endtask
	// watchdog: the whole run needs about five hundred cycles
	initial begin
		tick(20000);
		fail("timeout");
		report_and_stop();
	end
	// main sequence
	initial begin
		{resetn, psel, penable, pwrite, init_done, selftest_pass} = 6'h00;
		{at_sync_pos, carriage_fwd, line_step, line_fwd} = 4'h0;
		{gap_finished, error_event, mark_window_open, mark_seen} = 4'h0;
		{sheet_end, virt_mark_pending, teach_active} = 3'h0;
		{teach_captured, clear_req} = 2'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		carriage_pos = 32'h0000_1000;
		{enc_freq, virt_freq, corr_value} = 48'h0;
		delay = 8'h14;
		n_fail = 0;
		compares = 0;
		n_ret = 0;
		tick(1);
		chk({24'h0, output_connector}, 32'h0);
		tick(1);
		resetn <= 1'b1;
		rdc(`OFS_STATUS, 32'h0000_0000);
		rdc(`OFS_ROUTE_LO, `RST_ROUTE);
		rdc(`OFS_PULSE_DIV, `RST_PULSE_DIV);
		rdc(`OFS_MISS_LIMIT, `RST_MISS_LIMIT);
		rdc(`OFS_CTRL, `RST_CTRL);
		rdc(`OFS_ALARM_POS, 32'hFFFF_FFFF);
		wr(12'h030, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1);
		rdc(12'h030, 32'h0000_0000);
		// operational only when both conditions hold
		init_done <= 1'b1;
		st(`F_READY, 1'b0);
		selftest_pass <= 1'b1;
		st(`F_READY, 1'b1);
		wr(`OFS_ROUTE_LO, 32'h0000_0001);
		chk({31'h0, er}, 32'h0);
		ln(0, 1'b1);
		// ready and parked share line 0; home zone edges
		wr(`OFS_ROUTE_LO, 32'h0023_0121);
		wr(`OFS_HOME_LO, 32'h0000_0064);
		wr(`OFS_HOME_HI, 32'h0000_00C8);
		init_done <= 1'b0;
		ln(0, 1'b0);
		carriage_pos <= 32'h0000_0064;
		st(`F_PARKED, 1'b1);
		ln(0, 1'b1);
		carriage_pos <= 32'h0000_00C8;
		st(`F_PARKED, 1'b1);
		carriage_pos <= 32'h0000_00C9;
		st(`F_PARKED, 1'b0);
		// cut permit held until the slow cut-done answer
		at_sync_pos <= 1'b1;
		@(posedge clk);
		at_sync_pos <= 1'b0;
		st(`F_CUT_PERMIT, 1'b1);
		ln(1, 1'b1);
		tick(45);
		st(`F_CUT_PERMIT, 1'b0);
		// gap done waits for cut done, then one return pulse
		wr(`OFS_CTRL, 32'h0000_0003);
		delay <= 8'h1E;
		gap_finished <= 1'b1;
		@(posedge clk);
		gap_finished <= 1'b0;
		r0 = n_ret;
		st(`F_GAP_DONE, 1'b1);
		tick(60);
		chk(word_t'(n_ret - r0), 32'h1);
		st(`F_GAP_DONE, 1'b0);
		wr(`OFS_CTRL, `RST_CTRL);
		// two counts per half period: eight counts, two whole pulses
		wr(`OFS_PULSE_DIV, 32'h0000_0002);
		r0 = n_rise;
		h0 = n_high;
		steps(8, 1'b1);
		tick(6);
		chk(word_t'(n_rise - r0), 32'h2);
		chk(word_t'(n_high - h0), 32'h10);
		// motion flags against the standstill threshold
		wr(`OFS_ZERO_FREQ, 32'h0000_000A);
		enc_freq <= 16'h000A;
		virt_freq <= 16'h000B;
		st(`F_LINE_MOV, 1'b0);
		st(`F_SIM_MOV, 1'b1);
		enc_freq <= 16'h000B;
		virt_freq <= 16'h000A;
		st(`F_LINE_MOV, 1'b1);
		st(`F_SIM_MOV, 1'b0);
		// missing mark after three empty sheets, window flag
		sheet();
		sheet();
		st(`F_MISS_MARK, 1'b0);
		sheet();
		st(`F_MISS_MARK, 1'b1);
		mark_window_open <= 1'b1;
		st(`F_MARK_WIN, 1'b1);
		mark_seen <= 1'b1;
		@(posedge clk);
		mark_seen <= 1'b0;
		sheet();
		st(`F_MISS_MARK, 1'b0);
		mark_window_open <= 1'b0;
		st(`F_MARK_WIN, 1'b0);
		wr(`OFS_CTRL, 32'h0000_0000);
		st(`F_MARK_WIN, 1'b1);
		// synthetic mark, correction limit boundary, teach
		virt_mark_pending <= 1'b1;
		st(`F_SYNTH_MARK, 1'b1);
		wr(`OFS_MAX_CORR, 32'h0000_0032);
		corr_value <= 16'h0031;
		st(`F_CORR_LIM, 1'b0);
		corr_value <= 16'h0032;
		st(`F_CORR_LIM, 1'b1);
		teach_active <= 1'b1;
		teach_captured <= 1'b1;
		@(posedge clk);
		teach_captured <= 1'b0;
		teach_active <= 1'b0;
		st(`F_TEACH_DONE, 1'b1);
		// a new teach starting drops the old confirmation
		teach_active <= 1'b1;
		st(`F_TEACH_DONE, 1'b0);
		// alarm, error and reverse, then one clear for all
		wr(`OFS_ALARM_POS, 32'h0000_01F4);
		carriage_fwd <= 1'b1;
		carriage_pos <= 32'h0000_01F3;
		st(`F_ALARM, 1'b0);
		carriage_pos <= 32'h0000_01F4;
		st(`F_ALARM, 1'b1);
		carriage_fwd <= 1'b0;
		carriage_pos <= 32'h0000_1000;
		error_event <= 1'b1;
		@(posedge clk);
		error_event <= 1'b0;
		st(`F_FAULT, 1'b1);
		chk({31'h0, error_report}, 32'h1);
		// fault routed onto line 0, shared with ready and parked, both low
		wr(`OFS_ROUTE_LO, 32'h1023_0121);
		ln(0, 1'b1);
		wr(`OFS_REV_LIMIT, 32'h0000_0003);
		steps(3, 1'b0);
		st(`F_LINE_REV, 1'b0);
		steps(1, 1'b0);
		st(`F_LINE_REV, 1'b1);
		steps(3, 1'b1);
		st(`F_LINE_REV, 1'b1);
		steps(1, 1'b1);
		st(`F_LINE_REV, 1'b0);
		steps(4, 1'b0);
		st(`F_LINE_REV, 1'b1);
		clear_req <= 1'b1;
		@(posedge clk);
		clear_req <= 1'b0;
		tick(10);
		st(`F_LINE_REV, 1'b0);
		st(`F_ALARM, 1'b0);
		st(`F_FAULT, 1'b0);
		chk({31'h0, error_report}, 32'h0);
		ln(0, 1'b0);
		// the spare slot never drives a line
		wr(`OFS_ROUTE_LO, 32'h0000_0000);
		wr(`OFS_ROUTE_HI, 32'h1000_0000);
		rdc(`OFS_ROUTE_HI, 32'h1000_0000);
		ln(0, 1'b0);
		st(`F_UNUSED, 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire

// ==== verilog/shear_status_output_logic.sv ====
// status flags, length pulses, output routing and apb registers
// Operation
// - each flag routed to one of eight lines
// - line high while its routed flag active
// - all flags readable over the bus
// - ready only after init and passing selftest
// - cut permit raised when synchronous at position
// - cut permit held until cut done arrives
// - parked while carriage inside home zone
// - alarm when moving forward reaches alarm position
// - length pulses scaled from line travel
// - length pulse output has equal high, low
// - gap done, then wait cut done, return
// - line reverse set beyond reverse limit
// - line reverse cleared forward or fault clear
// - fault flag raised and reported on error
// - sim moving while virtual axis above standstill
// - missing mark after N sheets without mark
// - mark window flag, high when window disabled
// - synthetic mark flag while virtual mark pending
// - correction limit when correction reaches maximum
// - teach done once setpoint captured
// - several flags on one line are ORed
// - fault clear resets all error states
`include "shear_status_regs.svh"
`default_nettype none
module shear_status_output_logic #(
	parameter int POS_W = 32, // carriage and travel counter width
	parameter int FREQ_W = 16 // frequency and correction width
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire shear_status_pkg::word_t pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic init_done,
	input wire logic selftest_pass,
	input wire logic at_sync_pos,
	input wire logic [POS_W-1:0] carriage_pos,
	input wire logic carriage_fwd,
	input wire logic line_step,
	input wire logic line_fwd,
	input wire logic [FREQ_W-1:0] enc_freq,
	input wire logic [FREQ_W-1:0] virt_freq,
	input wire logic gap_finished,
	input wire logic error_event,
	input wire logic mark_window_open,
	input wire logic mark_seen,
	input wire logic sheet_end,
	input wire logic virt_mark_pending,
	input wire logic [FREQ_W-1:0] corr_value,
	input wire logic teach_active,
	input wire logic teach_captured,
	input wire logic cut_done_pin,
	input wire logic fault_clear_pin,
	output logic [`N_LINES-1:0] output_connector,
	output logic return_go,
	output logic error_report
);
	import shear_status_pkg::*;

	// configuration registers
	logic [2*32-1:0] route_q; // 4 bits per flag, 0 = no line
	logic [POS_W-1:0] home_lo_q, home_hi_q, alarm_pos_q, rev_limit_q;
	logic [POS_W-1:0] pulse_div_q;
	logic [FREQ_W-1:0] zero_freq_q, max_corr_q;
	logic [7:0] miss_limit_q;
	logic win_en_q, gap_en_q;
	// flag flops
	logic ready_q, cut_permit_q, parked_q, alarm_q, len_pulse_q;
	logic line_rev_q, fault_q, line_mov_q, sim_mov_q, miss_mark_q;
	logic mark_win_q, synth_mark_q, corr_lim_q, teach_done_q;
	logic [`N_FLAGS-1:0] flags; // view of all flag flops
	gap_state_t gap_q;
	logic return_go_q;
	logic [POS_W-1:0] len_cnt_q, rev_dist_q;
	logic [7:0] miss_cnt_q;
	logic mark_in_sheet_q; // a valid mark seen in this sheet
	logic [`N_LINES-1:0] out_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	// pin synchronisers: three stages, level accepted when 2 and 3 agree
	logic [1:0] pin_raw, s1_q, s2_q, s3_q, lvl_q, rise;
	assign pin_raw = {fault_clear_pin, cut_done_pin};
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_pin
			// stage one is read by stage two only
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s1_q[gp] <= 1'b0;
					s2_q[gp] <= 1'b0;
					s3_q[gp] <= 1'b0;
					lvl_q[gp] <= 1'b0;
				end else begin
					s1_q[gp] <= pin_raw[gp];
					s2_q[gp] <= s1_q[gp];
					s3_q[gp] <= s2_q[gp];
					if (s2_q[gp] == s3_q[gp]) begin
						lvl_q[gp] <= s3_q[gp];
					end
				end
			end
			assign rise[gp] = s2_q[gp] & s3_q[gp] & ~lvl_q[gp];
		end
	endgenerate
	logic cut_done, fault_clear;
	assign cut_done = rise[0];
	assign fault_clear = rise[1];

	// apb slave: no wait states, answer in the first access cycle
	logic acc, wr;
	assign acc = psel & penable & pready_q;
	assign wr = acc & pwrite & ~pslverr_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `RST_WORD;
		end else begin
			pready_q <= psel & ~penable;
			if (psel & ~penable) begin
				pslverr_q <= 1'b0;
				// address decode, unmapped reads zero with error
				if (paddr == `OFS_STATUS) begin
					prdata_q <= {16'h0000, flags};
				end else if (paddr == `OFS_ROUTE_LO) begin
					prdata_q <= route_q[31:0];
				end else if (paddr == `OFS_ROUTE_HI) begin
					prdata_q <= route_q[63:32];
				end else if (paddr == `OFS_HOME_LO) begin
					prdata_q <= 32'(home_lo_q);
				end else if (paddr == `OFS_HOME_HI) begin
					prdata_q <= 32'(home_hi_q);
				end else if (paddr == `OFS_ALARM_POS) begin
					prdata_q <= 32'(alarm_pos_q);
				end else if (paddr == `OFS_REV_LIMIT) begin
					prdata_q <= 32'(rev_limit_q);
				end else if (paddr == `OFS_ZERO_FREQ) begin
					prdata_q <= 32'(zero_freq_q);
				end else if (paddr == `OFS_PULSE_DIV) begin
					prdata_q <= 32'(pulse_div_q);
				end else if (paddr == `OFS_MISS_LIMIT) begin
					prdata_q <= {24'h000000, miss_limit_q};
				end else if (paddr == `OFS_CTRL) begin
					prdata_q <= {30'h0000_0000, gap_en_q, win_en_q};
				end else if (paddr == `OFS_MAX_CORR) begin
					prdata_q <= 32'(max_corr_q);
				end else begin
					prdata_q <= `RST_WORD;
					pslverr_q <= 1'b1;
				end
			end else if (!psel) begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// configuration writes take effect at the access edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			route_q <= {`RST_ROUTE, `RST_ROUTE};
			home_lo_q <= '0;
			home_hi_q <= '0;
			alarm_pos_q <= '1;
			rev_limit_q <= '0;
			zero_freq_q <= '0;
			pulse_div_q <= POS_W'(`RST_PULSE_DIV);
			miss_limit_q <= 8'(`RST_MISS_LIMIT);
			win_en_q <= 1'(`RST_CTRL >> `CTRL_WIN_EN);
			gap_en_q <= 1'(`RST_CTRL >> `CTRL_GAP_EN);
			max_corr_q <= '1;
		end else if (wr) begin
			if (paddr == `OFS_ROUTE_LO) begin
				route_q[31:0] <= pwdata;
			end else if (paddr == `OFS_ROUTE_HI) begin
				route_q[63:32] <= pwdata;
			end else if (paddr == `OFS_HOME_LO) begin
				home_lo_q <= POS_W'(pwdata);
			end else if (paddr == `OFS_HOME_HI) begin
				home_hi_q <= POS_W'(pwdata);
			end else if (paddr == `OFS_ALARM_POS) begin
				alarm_pos_q <= POS_W'(pwdata);
			end else if (paddr == `OFS_REV_LIMIT) begin
				rev_limit_q <= POS_W'(pwdata);
			end else if (paddr == `OFS_ZERO_FREQ) begin
				zero_freq_q <= FREQ_W'(pwdata);
			end else if (paddr == `OFS_PULSE_DIV) begin
				pulse_div_q <= POS_W'(pwdata);
			end else if (paddr == `OFS_MISS_LIMIT) begin
				miss_limit_q <= pwdata[7:0];
			end else if (paddr == `OFS_CTRL) begin
				win_en_q <= pwdata[`CTRL_WIN_EN];
				gap_en_q <= pwdata[`CTRL_GAP_EN];
			end else if (paddr == `OFS_MAX_CORR) begin
				max_corr_q <= FREQ_W'(pwdata);
			end
		end
	end

	// level flags derived straight from present conditions
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready_q <= 1'b0;
			parked_q <= 1'b0;
			line_mov_q <= 1'b0;
			sim_mov_q <= 1'b0;
			mark_win_q <= 1'b0;
			synth_mark_q <= 1'b0;
			corr_lim_q <= 1'b0;
		end else begin
			ready_q <= init_done & selftest_pass;
			parked_q <= (carriage_pos >= home_lo_q) &&
				(carriage_pos <= home_hi_q);
			line_mov_q <= enc_freq > zero_freq_q;
			sim_mov_q <= virt_freq > zero_freq_q;
			// disabled window lets every mark through
			mark_win_q <= ~win_en_q | mark_window_open;
			synth_mark_q <= virt_mark_pending;
			corr_lim_q <= corr_value >= max_corr_q;
		end
	end

	// cut permit: set wins over the cut done release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cut_permit_q <= 1'b0;
		end else if (at_sync_pos) begin
			cut_permit_q <= 1'b1;
		end else if (cut_done) begin
			cut_permit_q <= 1'b0;
		end
	end

	// alarm and fault: error states dropped by fault clear, set wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alarm_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			if (carriage_fwd && carriage_pos >= alarm_pos_q) begin
				alarm_q <= 1'b1;
			end else if (fault_clear) begin
				alarm_q <= 1'b0;
			end
			if (error_event) begin
				fault_q <= 1'b1;
			end else if (fault_clear) begin
				fault_q <= 1'b0;
			end
		end
	end

	// length pulses: output toggles every pulse_div forward steps,
	// so high and low each cover the same travel
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			len_cnt_q <= '0;
			len_pulse_q <= 1'b0;
		end else if (line_step && line_fwd) begin
			if (len_cnt_q + POS_W'(1) >= pulse_div_q) begin
				len_cnt_q <= '0;
				len_pulse_q <= ~len_pulse_q;
			end else begin
				len_cnt_q <= len_cnt_q + POS_W'(1);
			end
		end
	end

	// a reverse count that reaches past the limit in this cycle
	logic rev_hit;
	assign rev_hit = line_step & ~line_fwd &
		(rev_dist_q >= rev_limit_q);

	// reverse travel: distance grows backward, shrinks forward
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rev_dist_q <= '0;
			line_rev_q <= 1'b0;
		end else if (fault_clear) begin
			// set wins: a reverse count past the limit keeps the flag
			// and its distance, so forward travel can still undo it
			if (rev_hit) begin
				line_rev_q <= 1'b1;
			end else begin
				rev_dist_q <= '0;
				line_rev_q <= 1'b0;
			end
		end else if (line_step) begin
			if (!line_fwd) begin
				if (rev_dist_q != '1) begin
					rev_dist_q <= rev_dist_q + POS_W'(1);
				end
				if (rev_dist_q >= rev_limit_q) begin
					line_rev_q <= 1'b1;
				end
			end else if (rev_dist_q != '0) begin
				rev_dist_q <= rev_dist_q - POS_W'(1);
				if (rev_dist_q == POS_W'(1)) begin
					line_rev_q <= 1'b0;
				end
			end
		end
	end

	// an empty sheet that brings the count to the limit
	logic miss_hit;
	assign miss_hit = sheet_end & ~mark_in_sheet_q &
		~(mark_seen & mark_win_q) & (miss_cnt_q + 8'h01 >= miss_limit_q);

	// missing mark: counts sheets closed without a valid mark
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			miss_cnt_q <= '0;
			miss_mark_q <= 1'b0;
			mark_in_sheet_q <= 1'b0;
		end else if (fault_clear) begin
			miss_cnt_q <= '0;
			miss_mark_q <= miss_hit; // set wins
			mark_in_sheet_q <= 1'b0;
		end else if (sheet_end) begin
			mark_in_sheet_q <= 1'b0;
			if (mark_in_sheet_q || (mark_seen && mark_win_q)) begin
				miss_cnt_q <= '0;
				miss_mark_q <= 1'b0;
			end else begin
				if (miss_cnt_q != 8'hFF) begin
					miss_cnt_q <= miss_cnt_q + 8'h01;
				end
				if (miss_cnt_q + 8'h01 >= miss_limit_q) begin
					miss_mark_q <= 1'b1;
				end
			end
		end else if (mark_seen && mark_win_q) begin
			mark_in_sheet_q <= 1'b1;
		end
	end

	// teach done: captured set wins over a new teach starting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			teach_done_q <= 1'b0;
		end else if (teach_captured) begin
			teach_done_q <= 1'b1;
		end else if (teach_active) begin
			teach_done_q <= 1'b0;
		end
	end

	// gap sequence: flag up after the gap, return only on cut done
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= GAP_IDLE;
			return_go_q <= 1'b0;
		end else begin
			return_go_q <= 1'b0;
			case (gap_q)
				GAP_IDLE: begin
					if (gap_en_q && gap_finished) begin
						gap_q <= GAP_WAIT_CUT;
					end
				end
				GAP_WAIT_CUT: begin
					if (cut_done) begin
						gap_q <= GAP_IDLE;
						return_go_q <= 1'b1;
					end
				end
				default: begin
					gap_q <= GAP_IDLE;
				end
			endcase
		end
	end

	// flag vector; the spare slot is held inactive
	assign flags = {1'b0, teach_done_q, corr_lim_q, synth_mark_q,
		mark_win_q, miss_mark_q, sim_mov_q, line_mov_q, fault_q,
		line_rev_q, gap_q == GAP_WAIT_CUT, len_pulse_q, alarm_q,
		parked_q, cut_permit_q, ready_q};

	// routing: each line is the OR of flags whose route names it
	genvar gl;
	generate
		for (gl = 0; gl < `N_LINES; gl++) begin : g_line
			logic hit;
			always_comb begin
				hit = 1'b0;
				for (int f = 0; f < `N_FLAGS - 1; f++) begin
					if (route_q[f*`ROUTE_W +: `ROUTE_W] ==
						`ROUTE_W'(gl + 1)) begin
						hit = hit | flags[f];
					end
				end
			end
			// registered so lines sit low through reset
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					out_q[gl] <= 1'b0;
				end else begin
					out_q[gl] <= hit;
				end
			end
		end
	endgenerate

	assign output_connector = out_q;
	assign return_go = return_go_q;
	assign error_report = fault_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_ready_gate: assert property (
		ready_q |-> $past(init_done & selftest_pass))
		else $error("ready without init and selftest");
	chk_permit_hold: assert property (
		cut_permit_q && !cut_done |=> cut_permit_q)
		else $error("cut permit dropped without cut done");
	chk_permit_set: assert property (
		at_sync_pos |=> cut_permit_q)
		else $error("cut permit not raised");
	chk_alarm_set: assert property (
		carriage_fwd && carriage_pos >= alarm_pos_q |=> alarm_q)
		else $error("alarm not raised at position");
	chk_fault_clear: assert property (
		fault_clear && !error_event |=> !fault_q)
		else $error("fault survived fault clear");
	chk_gap_return: assert property (
		return_go_q |-> $past(gap_q == GAP_WAIT_CUT && cut_done))
		else $error("return without gap wait and cut done");
	chk_line_route: assert property (
		route_q[`F_FAULT*`ROUTE_W +: `ROUTE_W] == 4'h1 && fault_q
		&& $stable(route_q) |=> out_q[0])
		else $error("routed fault not on line one");
	chk_moving_flag: assert property (
		enc_freq > zero_freq_q |=> line_mov_q)
		else $error("line moving flag missing");
	chk_window_off: assert property (
		!win_en_q |=> mark_win_q)
		else $error("window flag low while disabled");
endmodule
`default_nettype wire
